// ---- design/gamma_dac_ctrl.sv ----
/*
 * two-wire slave front end and double-register dac bank for 18 gamma
 * and 2 common-electrode channels.
 * assumes: link_clk free-running and well faster than the bus clock;
 * the scl/sda pins are resolved outside (sda open-drain).
 */
// What this block does
// RULE1: general call 00h then 06h resets, both acked
// RULE2: general-call reset equals a full power cycle
// RULE3: ack gc address; nack gc data not 06h
// RULE4: power-up reset drives all outputs to midscale
// RULE5: address prefix 100 resets all outputs
// RULE6: address prefix 010 resets addressed channel only; code resets one channel per data word, the pointer advancing after each
// RULE7: output is low ref plus code span/1024
// RULE8: latch pin low: dac follows each storage write
// RULE9: latch pin high holds; falling edge copies all; code skips it if a bit-15-clear write or one-channel reset hits that cycle
// RULE10: bit 15 write copies all after full word
// RULE11: resets load dac stages whatever latch pin
// RULE12: common channels written independently of gamma ones
// RULE13: storage writes leave outputs until a latch
// RULE14: host preloads gamma 1-18 with bit 15 clear
// RULE15: midscale is code 512 in both stages
// RULE16: only channel addresses 0 to 19 acknowledged
// RULE17: data msb first, two low bits carry code
// RULE18: storage written only after both data bytes
// RULE19: channel auto-increments after each word until stop
`timescale 1ns/10ps
`default_nettype none

module gamma_dac_ctrl #(
    parameter logic [6:0] BUS_ADDR = gamma_dac_pkg::DEV_ADDR
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        load_latch_pin,
    output logic [17:0][9:0] gamma_outputs,
    output logic [1:0][9:0]  common_electrode_channel
);

    // ------------------------------------------------------------
    // link domain: reset and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0]  lrst_pipe;                 // reset release for link side
    logic        link_rst_n;
    logic        scl_meta, scl_s, scl_d;    // scl sync and history
    logic        sda_meta, sda_s, sda_d;    // sda sync and history

    assign link_rst_n = lrst_pipe[1];

    // release reset into the link domain through two flops
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_pipe <= 2'b00;
        end else begin
            lrst_pipe <= {lrst_pipe[0], 1'b1};
        end
    end

    // pins are asynchronous: two flops, then one more for edges
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            scl_d    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_s    <= scl_meta;
            scl_d    <= scl_s;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
            sda_d    <= sda_s;
        end
    end

    // ------------------------------------------------------------
    // link domain: bus conditions and byte engine
    // ------------------------------------------------------------
    logic        bus_start, bus_stop;       // sda edge while scl high
    logic        scl_rise, scl_fall;
    logic        byte_done;                 // eighth bit just ended
    gamma_dac_pkg::link_phase_e phase;      // which byte comes next
    logic [3:0]  bitcnt;                    // bits taken, 9 = ack slot
    logic [7:0]  shreg;                     // incoming byte
    logic [4:0]  chan;                      // current channel pointer
    logic        one_mode;                  // words reset, not write
    logic [7:0]  msb_byte;                  // held first data byte
    logic        ack_drive;                 // pulling sda low

    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign byte_done = scl_fall && (bitcnt == gamma_dac_pkg::BIT_LAST)
                       && (phase != gamma_dac_pkg::PH_IDLE)
                       && !bus_start && !bus_stop;

    // decode of the byte just taken
    logic                       next_ack;
    logic                       next_fire;
    gamma_dac_pkg::link_phase_e next_phase;
    logic [4:0]                 next_chan;
    logic                       next_one;
    logic [7:0]                 next_msb;
    gamma_dac_pkg::chan_evt_s   next_evt;
    logic [2:0]                 pfx;

    // decides ack, next phase and any event for the register side
    always_comb begin
        pfx        = shreg[7:5];
        next_ack   = 1'b0;
        next_fire  = 1'b0;
        next_phase = gamma_dac_pkg::PH_IGNORE;
        next_chan  = chan;
        next_one   = one_mode;
        next_msb   = msb_byte;
        next_evt   = '0;
        unique case (phase)
            gamma_dac_pkg::PH_DEVADDR: begin
                if (shreg == gamma_dac_pkg::GC_ADDR) begin
                    next_ack   = 1'b1;                       // [RULE3] [RULE1]
                    next_phase = gamma_dac_pkg::PH_GCDATA;
                end else if (shreg[7:1] == BUS_ADDR && !shreg[0]) begin
                    next_ack   = 1'b1;
                    next_phase = gamma_dac_pkg::PH_CHADDR;
                end
            end
            gamma_dac_pkg::PH_GCDATA: begin
                // only the reset value is acknowledged
                if (shreg == gamma_dac_pkg::GC_RESET) begin
                    next_ack      = 1'b1;                    // [RULE1] [RULE3]
                    next_fire     = 1'b1;                    // [RULE2]
                    next_evt.kind = gamma_dac_pkg::EV_RESET_ALL;
                end
            end
            gamma_dac_pkg::PH_CHADDR: begin
                if (gamma_dac_pkg::chan_ok(shreg[4:0]) &&
                    (pfx == gamma_dac_pkg::PFX_WRITE ||
                     pfx == gamma_dac_pkg::PFX_ONE ||
                     pfx == gamma_dac_pkg::PFX_ALL)) begin
                    next_ack   = 1'b1;                       // [RULE16]
                    next_chan  = shreg[4:0];
                    next_one   = (pfx == gamma_dac_pkg::PFX_ONE); // [RULE6]
                    next_phase = gamma_dac_pkg::PH_MSB;
                    if (pfx == gamma_dac_pkg::PFX_ALL) begin
                        next_fire     = 1'b1;                // [RULE5]
                        next_evt.kind = gamma_dac_pkg::EV_RESET_ALL;
                    end
                end
            end
            gamma_dac_pkg::PH_MSB: begin
                // pointer may have run past the map
                if (gamma_dac_pkg::chan_ok(chan)) begin
                    next_ack   = 1'b1;                       // [RULE16]
                    next_msb   = shreg;                      // [RULE17]
                    next_phase = gamma_dac_pkg::PH_LSB;
                end
            end
            gamma_dac_pkg::PH_LSB: begin
                next_ack          = 1'b1;
                next_fire         = 1'b1;                    // [RULE18]
                next_evt.kind     = one_mode ? gamma_dac_pkg::EV_RESET_ONE
                                             : gamma_dac_pkg::EV_WRITE;
                next_evt.chan     = chan;
                next_evt.hold_all = msb_byte[gamma_dac_pkg::HOLD_BIT];
                next_evt.code     = {msb_byte[1:0], shreg};  // [RULE17]
                next_chan         = chan + 5'h01;            // [RULE19]
                next_phase        = gamma_dac_pkg::PH_MSB;
            end
            gamma_dac_pkg::PH_IDLE, gamma_dac_pkg::PH_IGNORE: begin
                next_ack = 1'b0;
            end
            default: begin
                next_ack = 1'b0;
            end
        endcase
    end

    // byte engine; start or stop abandons any half-done word
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            phase     <= gamma_dac_pkg::PH_IDLE;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            chan      <= 5'h00;
            one_mode  <= 1'b0;
            msb_byte  <= 8'h00;
            ack_drive <= 1'b0;
        end else if (bus_start) begin
            phase     <= gamma_dac_pkg::PH_DEVADDR;          // [RULE18]
            bitcnt    <= 4'h0;
            ack_drive <= 1'b0;
        end else if (bus_stop) begin
            phase     <= gamma_dac_pkg::PH_IDLE;             // [RULE19]
            bitcnt    <= 4'h0;
            ack_drive <= 1'b0;
        end else if (phase != gamma_dac_pkg::PH_IDLE) begin
            if (scl_rise && bitcnt < gamma_dac_pkg::BIT_LAST) begin
                shreg  <= {shreg[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
            end else if (byte_done) begin
                // enter the ack slot with the decision made
                bitcnt    <= gamma_dac_pkg::BIT_ACK;
                ack_drive <= next_ack;
                phase     <= next_phase;
                chan      <= next_chan;
                one_mode  <= next_one;
                msb_byte  <= next_msb;
            end else if (scl_fall && bitcnt == gamma_dac_pkg::BIT_ACK) begin
                // a refused byte ends our part in the transfer
                bitcnt    <= 4'h0;
                ack_drive <= 1'b0;
                if (!ack_drive) begin
                    phase <= gamma_dac_pkg::PH_IGNORE;
                end
            end
        end
    end

    assign sda_out = 1'b0;       // open drain: only ever pulls low
    assign sda_oe  = ack_drive;

    // ------------------------------------------------------------
    // crossing: event word held stable, toggle announces it
    // ------------------------------------------------------------
    gamma_dac_pkg::chan_evt_s evt;          // held until next event
    logic                     req_tgl;      // flips once per event

    // events are at least one byte apart, far longer than the sync
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            evt     <= '0;
            req_tgl <= 1'b0;
        end else if (byte_done && next_fire) begin
            evt     <= next_evt;
            req_tgl <= ~req_tgl;
        end
    end

    // ------------------------------------------------------------
    // register domain: reset, event and latch-pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rrst_pipe;
    logic       ref_rst_n;
    logic       req_meta, req_s, req_d;
    logic       pin_meta, pin_s, pin_d;
    logic       evt_strobe;                 // one cycle per bus event
    logic       pin_fall;                   // latch pin went low

    assign ref_rst_n  = rrst_pipe[1];
    assign evt_strobe = req_s ^ req_d;
    assign pin_fall   = pin_d & ~pin_s;

    // release of the power-up reset through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rrst_pipe <= 2'b00;
        end else begin
            rrst_pipe <= {rrst_pipe[0], 1'b1};
        end
    end

    // toggle and latch pin each pass two flops before use.
    // pin history resets low, so a release never fakes a falling edge
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            req_meta <= 1'b0;
            req_s    <= 1'b0;
            req_d    <= 1'b0;
            pin_meta <= 1'b0;
            pin_s    <= 1'b0;
            pin_d    <= 1'b0;
        end else begin
            req_meta <= req_tgl;
            req_s    <= req_meta;
            req_d    <= req_s;
            pin_meta <= load_latch_pin;
            pin_s    <= pin_meta;
            pin_d    <= pin_s;
        end
    end

    // ------------------------------------------------------------
    // register domain: storage and dac stages
    // ------------------------------------------------------------
    logic [gamma_dac_pkg::NUM_CH-1:0][9:0] storage;  // first stage
    logic [gamma_dac_pkg::NUM_CH-1:0][9:0] dac;      // drives outputs
    logic is_write, is_all, is_one;

    assign is_write = evt_strobe && evt.kind == gamma_dac_pkg::EV_WRITE;
    assign is_all   = evt_strobe && evt.kind == gamma_dac_pkg::EV_RESET_ALL;
    assign is_one   = evt_strobe && evt.kind == gamma_dac_pkg::EV_RESET_ONE;

    // storage stage: each channel written alone
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            storage <= {gamma_dac_pkg::NUM_CH{gamma_dac_pkg::MID_CODE}}; // [RULE15]
        end else if (is_all) begin
            storage <= {gamma_dac_pkg::NUM_CH{gamma_dac_pkg::MID_CODE}}; // [RULE2]
        end else if (is_one) begin
            storage[evt.chan] <= gamma_dac_pkg::MID_CODE;                // [RULE6]
        end else if (is_write) begin
            storage[evt.chan] <= evt.code;                   // [RULE12] [RULE13]
        end
    end

    // dac stage: resets first, then writes, then the pin edge.
    // each code is a count of span/1024 steps above the low reference
    always_ff @(posedge ref_clk or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            dac <= {gamma_dac_pkg::NUM_CH{gamma_dac_pkg::MID_CODE}};     // [RULE4]
        end else if (is_all) begin
            dac <= {gamma_dac_pkg::NUM_CH{gamma_dac_pkg::MID_CODE}};     // [RULE11]
        end else if (is_one) begin
            dac[evt.chan] <= gamma_dac_pkg::MID_CODE;                    // [RULE6]
        end else if (is_write && evt.hold_all) begin
            // new word plus every held storage value together
            for (int i = 0; i < gamma_dac_pkg::NUM_CH; i++) begin
                dac[i] <= (5'(i) == evt.chan) ? evt.code : storage[i]; // [RULE10]
            end
        end else if (is_write && !pin_s) begin
            dac[evt.chan] <= evt.code;                       // [RULE8] [RULE7]
        end else if (pin_fall) begin
            dac <= storage;                                  // [RULE9]
        end
    end

    assign gamma_outputs            = dac[gamma_dac_pkg::NUM_GAMMA-1:0];
    assign common_electrode_channel = dac[gamma_dac_pkg::NUM_CH-1:gamma_dac_pkg::NUM_GAMMA];

    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    a_gc_addr_ack: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE3]
        byte_done && phase == gamma_dac_pkg::PH_DEVADDR && shreg == 8'h00
        |=> ack_drive ##1 ack_drive[*1]) else $error("gc address not acked");
    a_gc_data_nack: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE3]
        byte_done && phase == gamma_dac_pkg::PH_GCDATA && shreg != 8'h06
        |=> !ack_drive) else $error("bad gc data acked");
    a_chan_range: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE16]
        byte_done && phase == gamma_dac_pkg::PH_CHADDR && shreg[4:0] > 5'h13
        |=> !ack_drive && phase == gamma_dac_pkg::PH_IGNORE) else $error("bad chan acked");
    a_addr_incr: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE19]
        byte_done && phase == gamma_dac_pkg::PH_LSB
        |=> chan == $past(chan) + 5'h01 && req_tgl != $past(req_tgl))
        else $error("pointer not advanced");
    a_por_mid: assert property (@(posedge ref_clk) // [RULE4]
        $rose(ref_rst_n) |-> dac[0] == 10'h200 && dac[19] == 10'h200)
        else $error("reset value not midscale");
    a_reset_all: assert property (@(posedge ref_clk) disable iff (!ref_rst_n) // [RULE11]
        is_all |=> dac[0] == 10'h200 && storage[19] == 10'h200)
        else $error("reset did not load dac");
    a_pin_low_follow: assert property (@(posedge ref_clk) disable iff (!ref_rst_n) // [RULE8]
        is_write && !pin_s |=> dac[$past(evt.chan)] == $past(evt.code))
        else $error("dac did not follow write");
    a_pin_high_hold: assert property (@(posedge ref_clk) disable iff (!ref_rst_n) // [RULE9]
        is_write && pin_s && !evt.hold_all |=> $stable(dac))
        else $error("dac moved while latched");
    a_pin_fall_copy: assert property (@(posedge ref_clk) disable iff (!ref_rst_n) // [RULE9]
        pin_fall && !evt_strobe |=> dac == $past(storage))
        else $error("pin edge did not copy");
    a_sw_latch: assert property (@(posedge ref_clk) disable iff (!ref_rst_n) // [RULE10]
        is_write && evt.hold_all |=> dac == storage)
        else $error("software latch failed");

    c_gc_reset: cover property (@(posedge ref_clk) disable iff (!ref_rst_n) is_all);
    c_sw_latch: cover property (@(posedge ref_clk) disable iff (!ref_rst_n)
        is_write && evt.hold_all && pin_s);
    c_pin_latch: cover property (@(posedge ref_clk) disable iff (!ref_rst_n) pin_fall);
    c_reset_one: cover property (@(posedge ref_clk) disable iff (!ref_rst_n) is_one);

endmodule : gamma_dac_ctrl

`default_nettype wire

// ---- design/gamma_dac_pkg.sv ----
/*
 * constants, types and helpers shared by the gamma dac control block.
 * assumes nothing of its surroundings; compiled before the design.
 */
package gamma_dac_pkg;

    // ------------------------------------------------------------
    // channel map and codes
    // ------------------------------------------------------------
    localparam int         NUM_CH    = 20;      // 18 gamma + 2 common
    localparam int         NUM_GAMMA = 18;      // gamma channels first
    localparam int         DAC_STEPS = 1024;    // steps across span
    localparam logic [4:0] LAST_CH   = 5'h13;   // highest valid channel
    localparam logic [9:0] MID_CODE  = 10'h200; // half-span reset code
    localparam logic [6:0] DEV_ADDR  = 7'h74;   // default bus address

    // ------------------------------------------------------------
    // byte values and fields of the bus protocol
    // ------------------------------------------------------------
    localparam logic [7:0] GC_ADDR   = 8'h00;   // general-call address
    localparam logic [7:0] GC_RESET  = 8'h06;   // general-call reset
    localparam logic [2:0] PFX_WRITE = 3'h0;    // plain channel write
    localparam logic [2:0] PFX_ONE   = 3'h2;    // reset one channel
    localparam logic [2:0] PFX_ALL   = 3'h4;    // reset all channels
    localparam int         HOLD_BIT  = 7;       // bit 15 inside msb byte
    localparam logic [3:0] BIT_LAST  = 4'h8;    // eight data bits taken
    localparam logic [3:0] BIT_ACK   = 4'h9;    // inside the ack slot

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EV_WRITE     = 2'b00,
        EV_RESET_ALL = 2'b01,
        EV_RESET_ONE = 2'b10
    } evt_kind_e;

    // one finished bus action handed to the register side
    typedef struct packed {
        evt_kind_e   kind;
        logic [4:0]  chan;
        logic        hold_all;  // software latch request
        logic [9:0]  code;
    } chan_evt_s;

    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_DEVADDR = 3'b001,
        PH_GCDATA  = 3'b010,
        PH_CHADDR  = 3'b011,
        PH_MSB     = 3'b100,
        PH_LSB     = 3'b101,
        PH_IGNORE  = 3'b110
    } link_phase_e;

    // channel index lies inside the map
    function automatic logic chan_ok(input logic [4:0] c);
        return c <= LAST_CH;
    endfunction : chan_ok

endpackage : gamma_dac_pkg

// ---- tb/gamma_dac_latch_reset_control_tb.sv ----
/* self-checking bench for the gamma dac control block.
   assumes the master model drives the bus; the pull-up lives here. */
`timescale 1ns/10ps
`default_nettype none
module gamma_dac_latch_reset_control_tb;
    localparam logic [19:0][9:0] MID_ALL = {20{gamma_dac_pkg::MID_CODE}};
    logic             ref_clk = 1'b0; // 200 MHz
    logic             link_clk;       // 30 ns, own phase
    logic             rst_n;
    logic             pin;            // latch pin drive
    logic             scl;
    logic             sda_drv;        // master side, 1 = released
    logic             sda_out;
    logic             sda_oe;
    logic             sda_bus;        // resolved open-drain line
    logic [17:0][9:0] gam;
    logic [1:0][9:0]  com;
    logic [19:0][9:0] dac_all;        // commons on top
    logic [19:0][9:0] st;             // expected storage stage
    logic [19:0][9:0] dac;            // expected dac stage
    logic [2:0]       pfx [3] = '{3'h0, 3'h2, 3'h4};
    int               n_errors = 0;
    int               n_compared = 0;
    assign sda_bus = sda_drv & ~(sda_oe & ~sda_out);
    assign dac_all = {com, gam};
    always #2.5 ref_clk = ~ref_clk;
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #15 link_clk = ~link_clk;
    end
    gamma_dac_ctrl i_gamma_dac_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
        .load_latch_pin(pin), .gamma_outputs(gam), .common_electrode_channel(com));
    gamma_master_model i_gamma_master_model (.ref_clk(ref_clk), .sda_bus(sda_bus),
        .scl(scl), .sda_drv(sda_drv));
    // ------------------------------------------------------------
    // comparison and stimulus tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic check_all();
        for (int c = 0; c < 20; c++)
            chk("dac code", 16'(dac_all[c]), 16'(dac[c]));
    endtask : check_all
    task automatic set_pin(input logic v);
        @(negedge ref_clk);
        if (pin === 1'b1 && !v)
            dac = st; // falling pin copies all
        pin = v;
        repeat (8) @(negedge ref_clk);
    endtask : set_pin
    task automatic xfer(input logic [7:0] cb, input int n, input logic hold, input logic half);
        logic        a;
        logic        ok;
        logic [4:0]  c;
        logic [15:0] w;
        c = cb[4:0];
        ok = c <= 5'd19 && cb[7:5] inside {3'h0, 3'h2, 3'h4};
        if (cb[7:5] != 3'h0)
            n = int'(cb[6]); // one word after 010, none after 100
        i_gamma_master_model.start();
        i_gamma_master_model.sbyte({gamma_dac_pkg::DEV_ADDR, 1'b0}, a);
        chk("address ack", 16'(a), 16'h0001);
        i_gamma_master_model.sbyte(cb, a);
        chk("channel ack", 16'(a), 16'(ok));
        if (ok && cb[7:5] == 3'h4) begin
            st = MID_ALL;
            dac = MID_ALL;
        end
        for (int i = 0; i < n && ok; i++) begin
            w = {hold && cb[7:5] == 3'h0, 5'h00, 10'($urandom)};
            ok = c <= 5'd19;
            i_gamma_master_model.sbyte(w[15:8], a);
            chk("msb ack", 16'(a), 16'(ok));
            if (ok) begin
                i_gamma_master_model.sbyte(w[7:0], a);
                chk("lsb ack", 16'(a), 16'h0001);
                if (cb[7:5] == 3'h2)
                    w[9:0] = gamma_dac_pkg::MID_CODE;
                st[c] = w[9:0];
                if (!pin || cb[7:5] == 3'h2)
                    dac[c] = st[c];
                if (w[15])
                    dac = st;
                c++;
            end
        end
        if (half && ok) begin
            i_gamma_master_model.sbyte(8'h03, a); // word cut short
            chk("cut msb ack", 16'(a), 16'(c <= 5'd19));
        end
        i_gamma_master_model.stop();
        repeat (20) @(negedge ref_clk);
        check_all();
    endtask : xfer
    task automatic gc(input logic [7:0] d);
        logic a;
        i_gamma_master_model.start();
        i_gamma_master_model.sbyte(8'h00, a);
        chk("call ack", 16'(a), 16'h0001);
        i_gamma_master_model.sbyte(d, a);
        chk("call data ack", 16'(a), 16'(d == 8'h06));
        if (d == 8'h06) begin
            st = MID_ALL;
            dac = MID_ALL;
        end
        i_gamma_master_model.stop();
        repeat (20) @(negedge ref_clk);
        check_all();
    endtask : gc
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        int s;
        s = $urandom(32'hc4936888);
        rst_n = 1'b0;
        pin = 1'b0;
        st = MID_ALL;
        dac = MID_ALL;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        check_all();
        xfer(8'h00, 20, 1'b0, 1'b0);
        xfer(8'h13, 2, 1'b0, 1'b0); // pointer runs past the map
        set_pin(1'b1);
        xfer(8'h00, 18, 1'b0, 1'b0); // preload, bit 15 clear
        xfer(8'h12, 2, 1'b0, 1'b0);
        set_pin(1'b0);
        xfer(8'h12, 1, 1'b0, 1'b1);
        set_pin(1'b1);
        xfer(8'h05, 1, 1'b1, 1'b0);
        xfer(8'h14, 1, 1'b0, 1'b0);
        xfer(8'h23, 1, 1'b0, 1'b0);
        xfer(8'h4a, 1, 1'b0, 1'b0);
        xfer(8'h91, 0, 1'b0, 1'b0);
        xfer(8'h02, 3, 1'b0, 1'b0);
        gc(8'h05);
        gc(8'h06); // pin still high
        for (int k = 0; k < 5; k++) begin
            set_pin(1'($urandom));
            xfer({pfx[$urandom % 3], 5'($urandom % 20)}, 1 + $urandom % 3,
                 1'($urandom), 1'($urandom));
        end
        end_sim();
    end
    initial begin
        repeat (95000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end
endmodule : gamma_dac_latch_reset_control_tb
`default_nettype wire

// ---- tb/gamma_master_model.sv ----
/* two-wire bus master model standing in for the panel timing controller.
   assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module gamma_master_model (
    input  wire logic ref_clk,
    input  wire logic sda_bus,
    output logic      scl,
    output logic      sda_drv
);
    // ------------------------------------------------------------
    // bus phases, all moves made on falling ref_clk edges
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // quarter bit: 13 cycles keeps scl high/low above 4 link clocks
    task automatic q(input int n);
        repeat (n * 13) @(negedge ref_clk);
    endtask : q
    // start works from idle and as a repeated start
    task automatic start();
        sda_drv = 1'b1;
        q(1);
        scl = 1'b1;
        q(1);
        sda_drv = 1'b0;
        q(1);
        scl = 1'b0;
        q(1);
    endtask : start
    task automatic stop();
        sda_drv = 1'b0;
        q(1);
        scl = 1'b1;
        q(1);
        sda_drv = 1'b1;
        q(2);
    endtask : stop
    // one bit; the line is sampled late in the high phase
    task automatic bit_slot(input logic v, output logic s);
        sda_drv = v;
        q(1);
        scl = 1'b1;
        q(2);
        s = sda_bus;
        scl = 1'b0;
        q(1);
    endtask : bit_slot
    // byte sent msb first, then the ack slot with sda released
    task automatic sbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask : sbyte
endmodule : gamma_master_model
`default_nettype wire
